//--- inc/tpc_defs.svh
// register offsets, field positions, reset values for the pma control/test bank
// assumes clause 45 addressing resolved upstream to device and register address
`ifndef TPC_DEFS_SVH
`define TPC_DEFS_SVH

`define TPC_DEV_PMA         5'h01
`define TPC_ADDR_CTRL       16'h08F6
`define TPC_ADDR_STAT       16'h08F7
`define TPC_ADDR_TEST       16'h08F8

`define TPC_CTRL_TXDIS_BIT  14
`define TPC_CTRL_AMP_BIT    12
`define TPC_CTRL_EEE_BIT    10
`define TPC_CTRL_LB_BIT     0
`define TPC_CTRL_RST        16'h0000

`define TPC_STAT_LB_BIT     13
`define TPC_STAT_HIAMP_BIT  12
`define TPC_STAT_PD_BIT     11
`define TPC_STAT_EEE_BIT    10
`define TPC_STAT_RST        16'h2800

`define TPC_TEST_LSB        13
`define TPC_TEST_RST        3'h0

`define TPC_DROOP_RUN       4'h9

`endif

//--- inc/tpc_pkg.sv
// types for the pma control/test register bank
// assumes nothing beyond a systemverilog compiler
package tpc_pkg;

	typedef enum logic [2:0] {
		TPC_TM_NORMAL = 3'h0,
		TPC_TM_ALT    = 3'h1,
		TPC_TM_DROOP  = 3'h2,
		TPC_TM_IDLE   = 3'h3
	} tpc_test_e;

	// management access as decoded from a clause 45 frame
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [4:0]  dev;
		logic [15:0] addr;
		logic [15:0] wdata;
	} tpc_req_s;

	// symbol on the transmit and receive paths
	typedef struct packed {
		logic        valid;
		logic [1:0]  sym;
	} tpc_sym_s;

	typedef logic [1:0] tpc_sym_t;

endpackage : tpc_pkg

//--- logic/tpc_regs.sv
// pma control, status and transmitter test-mode registers with tx path gating
// assumes a clause 45 frame engine upstream presenting one-cycle rd/wr requests
//
// What this block does
// [RULE1] transmit disable bit 14 silences tx output
// [RULE2] bit 12: one means 2.4 V amplitude
// [RULE3] amplitude bit used only without autonegotiation
// [RULE4] loopback bit 0 returns tx data to rx
// [RULE5] control at 0x08F6 device 1, resets zero; code loads bit 12 from the strap on the first edge after reset
// [RULE6] status at 0x08F7 reads 0x2800 after reset; code reads 0x3800 when the strap is high
// [RULE7] status bit 13 loopback ability reads one
// [RULE8] status bit 12 follows high amplitude strap
// [RULE9] status bit 11 power-down ability reads one
// [RULE10] status bit 10 reads zero; control 10 enables
// [RULE11] test field bits 15:13 at 0x08F8, resets 000
// [RULE12] mode 001 repeats +1, -1
// [RULE13] mode 010 sends ten +1, ten -1
// [RULE14] mode 011 behaves as normal idle leader
// [RULE15] modes 100-111 normal; reserved bits read zero
`timescale 1ns/1ns
`include "tpc_defs.svh"

module tpc_regs #(
	parameter int DROOP_LEN = 10
) (
	// clock and reset
	input  wire logic             clk_sys,
	input  wire logic             sys_rst,
	// strap for high amplitude capability, sampled after reset release
	input  wire logic             strap_high_amplitude,
	// autonegotiation
	input  wire logic             an_enable,
	input  wire logic             an_amplitude_high,
	// management request and read answer
	input  wire tpc_pkg::tpc_req_s mgmt_req,
	output logic [15:0]           mgmt_rdata,
	output logic                  mgmt_rvalid,
	// transmit path from pcs
	input  wire tpc_pkg::tpc_sym_s pcs_tx,
	output tpc_pkg::tpc_sym_s     pma_tx,
	// receive path
	input  wire tpc_pkg::tpc_sym_s line_rx,
	output tpc_pkg::tpc_sym_s     pma_rx,
	// control levels toward analog and pcs
	output logic                  transmit_amplitude_high,
	output logic                  energy_efficient_enable
);
	import tpc_pkg::*;

	initial begin
		if (DROOP_LEN < 1 || DROOP_LEN > 16)
			$error("DROOP_LEN out of range");
	end

	// symbol codes: 01 is +1, 11 is -1, 00 is zero/idle
	localparam tpc_sym_t SYM_POS  = 2'h1;
	localparam tpc_sym_t SYM_NEG  = 2'h3;
	localparam tpc_sym_t SYM_ZERO = 2'h0;

	// ************************************************************
	// register state
	// ************************************************************
	logic        transmit_disable_q;
	logic        amp_q;
	logic        energy_efficient_enable_q;
	logic        local_loopback_enable_q;
	logic [2:0]  transmitter_test_select_q;
	logic        high_amplitude_ability_q;
	logic        strap_taken_q;

	function automatic logic hit(input tpc_req_s r, input logic [15:0] a);
		hit = (r.dev == `TPC_DEV_PMA) && (r.addr == a);
	endfunction : hit

	wire logic wr_ctrl = mgmt_req.wr && hit(mgmt_req, `TPC_ADDR_CTRL); // RULE5
	wire logic wr_test = mgmt_req.wr && hit(mgmt_req, `TPC_ADDR_TEST); // RULE11

	// ************************************************************
	// control and test registers
	// ************************************************************
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			transmit_disable_q        <= 1'b0; // RULE5
			energy_efficient_enable_q <= 1'b0;
			local_loopback_enable_q   <= 1'b0;
			transmitter_test_select_q <= `TPC_TEST_RST; // RULE11
		end else if (wr_ctrl) begin
			transmit_disable_q        <= mgmt_req.wdata[`TPC_CTRL_TXDIS_BIT];
			energy_efficient_enable_q <= mgmt_req.wdata[`TPC_CTRL_EEE_BIT]; // RULE10
			local_loopback_enable_q   <= mgmt_req.wdata[`TPC_CTRL_LB_BIT];
		end else if (wr_test) begin
			transmitter_test_select_q <= mgmt_req.wdata[15:`TPC_TEST_LSB];
		end
	end

	// amplitude bit and ability take the strap value on the first edge after reset
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			strap_taken_q            <= 1'b0;
			amp_q                    <= 1'b0;
			high_amplitude_ability_q <= 1'b0;
		end else if (!strap_taken_q) begin
			strap_taken_q            <= 1'b1;
			amp_q                    <= strap_high_amplitude;
			high_amplitude_ability_q <= strap_high_amplitude; // RULE8
		end else if (wr_ctrl) begin
			amp_q <= mgmt_req.wdata[`TPC_CTRL_AMP_BIT]; // RULE2
		end
	end

	// ************************************************************
	// read path
	// ************************************************************
	wire logic [15:0] ctrl_view = {1'b0, transmit_disable_q, 1'b0, amp_q, 1'b0,
	                               energy_efficient_enable_q, 9'h000, local_loopback_enable_q};
	wire logic [15:0] stat_view = {2'h0, 1'b1, high_amplitude_ability_q, 1'b1, 1'b0, 10'h000}; // RULE6 RULE7 RULE9 RULE10
	wire logic [15:0] test_view = {transmitter_test_select_q, 13'h0000}; // RULE15
	wire logic [15:0] rd_mux    = hit(mgmt_req, `TPC_ADDR_CTRL) ? ctrl_view :
	                              hit(mgmt_req, `TPC_ADDR_STAT) ? stat_view :
	                              hit(mgmt_req, `TPC_ADDR_TEST) ? test_view : 16'h0000;

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			mgmt_rdata  <= 16'h0000;
			mgmt_rvalid <= 1'b0;
		end else begin
			mgmt_rvalid <= mgmt_req.rd;
			mgmt_rdata  <= mgmt_req.rd ? rd_mux : mgmt_rdata;
		end
	end

	// ************************************************************
	// test pattern generator
	// ************************************************************
	tpc_test_e   mode;
	logic [3:0]  run_q;
	logic        phase_q;

	always_comb begin
		unique case (transmitter_test_select_q)
			3'h1:    mode = TPC_TM_ALT;   // RULE12
			3'h2:    mode = TPC_TM_DROOP; // RULE13
			3'h3:    mode = TPC_TM_IDLE;  // RULE14
			default: mode = TPC_TM_NORMAL; // RULE15
		endcase
	end

	wire logic       run_end = (run_q == 4'(DROOP_LEN - 1));
	wire tpc_sym_t   pat_sym = phase_q ? SYM_NEG : SYM_POS;
	wire logic       in_test = (mode == TPC_TM_ALT) || (mode == TPC_TM_DROOP);

	always_ff @(posedge clk_sys) begin
		if (sys_rst || !in_test) begin
			run_q   <= 4'h0;
			phase_q <= 1'b0;
		end else if (mode == TPC_TM_ALT) begin
			run_q   <= 4'h0;
			phase_q <= !phase_q; // RULE12
		end else if (run_end) begin
			run_q   <= 4'h0;
			phase_q <= !phase_q; // RULE13
		end else begin
			run_q <= run_q + 4'h1;
		end
	end

	// ************************************************************
	// transmit, receive and amplitude outputs
	// ************************************************************
	wire tpc_sym_s tx_src = in_test ? '{valid: 1'b1, sym: pat_sym} : pcs_tx; // RULE14
	wire tpc_sym_s tx_out = transmit_disable_q ? '{valid: 1'b0, sym: SYM_ZERO} : tx_src; // RULE1
	wire tpc_sym_s rx_out = local_loopback_enable_q ? tx_src : line_rx; // RULE4
	wire logic     amp_d  = an_enable ? an_amplitude_high : amp_q; // RULE3

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			pma_tx                  <= '0;
			pma_rx                  <= '0;
			transmit_amplitude_high <= 1'b0;
			energy_efficient_enable <= 1'b0;
		end else begin
			pma_tx                  <= tx_out;
			pma_rx                  <= rx_out;
			transmit_amplitude_high <= amp_d;
			energy_efficient_enable <= energy_efficient_enable_q;
		end
	end

endmodule : tpc_regs

//--- tb/tpc_regs_props.sv
// assertions on the ports of tpc_regs
// assumes tpc_pkg is compiled first and the bind at the foot
`timescale 1ns/1ns
`include "tpc_defs.svh"
module tpc_regs_props import tpc_pkg::*; (
	input wire logic        clk_sys, sys_rst, strap_high_amplitude, an_enable, an_amplitude_high,
	input wire tpc_req_s    mgmt_req,
	input wire logic [15:0] mgmt_rdata,
	input wire logic        mgmt_rvalid, transmit_amplitude_high, energy_efficient_enable,
	input wire tpc_sym_s    pcs_tx, pma_tx, line_rx, pma_rx
);
	logic [2:0] md_q;
	logic       ds_q, lb_q, rs_q;
	wire        wr_hit = mgmt_req.wr && mgmt_req.dev == `TPC_DEV_PMA;
	wire        rd_hit = mgmt_req.rd && mgmt_req.dev == `TPC_DEV_PMA;
	// mirror of test mode, disable and loopback
	always_ff @(posedge clk_sys) begin
		rs_q <= sys_rst;
		if (sys_rst)
			{md_q, ds_q, lb_q} <= 5'h00;
		else if (wr_hit && mgmt_req.addr == `TPC_ADDR_TEST)
			md_q <= mgmt_req.wdata[15:13];
		else if (wr_hit && mgmt_req.addr == `TPC_ADDR_CTRL)
			{ds_q, lb_q} <= {mgmt_req.wdata[14], mgmt_req.wdata[0]};
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	sequence s_alt; (md_q == 3'h1 && !ds_q)[*2] ##0 pma_tx.sym == 2'h1; endsequence
	sequence s_pass; !rs_q && !ds_q && (md_q == 3'h0 || md_q == 3'h3 || md_q[2]); endsequence
	property p_alt; s_alt |=> pma_tx == 3'h7; endproperty
	property p_dis; ds_q && !rs_q |=> pma_tx == 3'h0; endproperty
	property p_pass; s_pass |=> pma_tx == $past(pcs_tx); endproperty
	property p_lbk; lb_q && !ds_q && !rs_q |=> pma_rx == pma_tx; endproperty
	property p_rx; !lb_q && !rs_q |=> pma_rx == $past(line_rx); endproperty
	property p_stat; rd_hit && mgmt_req.addr == `TPC_ADDR_STAT |=> (mgmt_rdata & 16'hEFFF) == 16'h2800; endproperty
	property p_test; rd_hit && mgmt_req.addr == `TPC_ADDR_TEST |=> mgmt_rdata == {md_q, 13'h0000}; endproperty
	property p_unm; mgmt_req.rd && !(rd_hit && mgmt_req.addr inside {[`TPC_ADDR_CTRL:`TPC_ADDR_TEST]})
		|=> mgmt_rvalid && mgmt_rdata == 16'h0000; endproperty
	property p_amp; an_enable && !rs_q |=> transmit_amplitude_high == $past(an_amplitude_high); endproperty
	a_alt: assert property (p_alt) else $error("mode 1 pattern wrong");
	a_dis: assert property (p_dis) else $error("tx not silenced");
	a_pass: assert property (p_pass) else $error("tx not passed");
	a_lbk: assert property (p_lbk) else $error("loopback wrong");
	a_rx: assert property (p_rx) else $error("rx not passed");
	a_stat: assert property (p_stat) else $error("status value wrong");
	a_test: assert property (p_test) else $error("test field wrong");
	a_unm: assert property (p_unm) else $error("unmapped read wrong");
	a_amp: assert property (p_amp) else $error("negotiated amplitude ignored");
endmodule : tpc_regs_props

bind tpc_regs tpc_regs_props i_tpc_regs_props (.*);

//--- tb/tpc_pcs_model.sv
// pcs and line side symbol source
// assumes symbols change at the falling edge
`timescale 1ns/1ns
module tpc_pcs_model import tpc_pkg::*; (
	input wire logic clk_sys,
	output tpc_sym_s pcs_tx,
	output tpc_sym_s line_rx
);
	logic [3:0] n_q = 4'h0;
	always @(negedge clk_sys) n_q <= n_q + 4'h1;
	assign pcs_tx  = {n_q[0], n_q[2:1]};
	assign line_rx = {~n_q[0], n_q[3:2]};
endmodule : tpc_pcs_model

//--- tb/tpc_regs_test.sv
// self-checking bench for tpc_regs
// assumes tpc_pkg, the checker and the pcs model compiled first
`timescale 1ns/1ns
`include "tpc_defs.svh"
module tpc_regs_test import tpc_pkg::*;;
	logic        clk_sys = 1'b0, sys_rst = 1'b1, strap_high_amplitude = 1'b1;
	logic        an_enable = 1'b0, an_amplitude_high = 1'b0;
	tpc_req_s    mgmt_req = '0;
	tpc_sym_s    pcs_tx, pma_tx, line_rx, pma_rx;
	logic [15:0] mgmt_rdata;
	logic        mgmt_rvalid, transmit_amplitude_high, energy_efficient_enable;
	int          num_errors = 0, n_tests = 0;
	always #4 clk_sys = ~clk_sys;
	tpc_pcs_model i_tpc_pcs_model (.*);
	tpc_regs #(.DROOP_LEN(10)) i_tpc_regs (.*);
	task automatic final_report();
		$display("errors %0d checks %0d", num_errors, n_tests);
		if (num_errors == 0 && n_tests > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : final_report
	task automatic chk(string nm, logic [15:0] got, logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD %s exp %h got %h", nm, exp, got);
		end
	endtask : chk
	task automatic acc(logic [1:0] op, logic [15:0] a, logic [15:0] d);
		@(negedge clk_sys) mgmt_req = {op, `TPC_DEV_PMA, a, d};
		@(negedge clk_sys) mgmt_req = '0;
	endtask : acc
	task automatic rd(logic [15:0] a, logic [15:0] exp, string nm);
		acc(2'b01, a, 16'h0000);
		chk("rvalid", {15'h0000, mgmt_rvalid}, 16'h0001);
		chk(nm, mgmt_rdata, exp);
	endtask : rd
	task automatic pat(int len);
		int k;
		for (k = 0; k < 50 && pma_tx.sym !== 2'h3; k++) @(negedge clk_sys);
		if (k == 50) begin
			num_errors++;
			final_report();
		end
		for (k = 0; k < 50 && pma_tx.sym !== 2'h1; k++) @(negedge clk_sys);
		if (k == 50) begin
			num_errors++;
			final_report();
		end
		for (k = 0; k < 4 * len; k++) begin
			chk("pattern", {13'h0000, pma_tx}, (k % (2 * len) < len) ? 16'h0005 : 16'h0007);
			@(negedge clk_sys);
		end
	endtask : pat
	initial begin
		repeat (3) @(negedge clk_sys);
		sys_rst = 1'b0;
		repeat (2) @(negedge clk_sys);
		rd(`TPC_ADDR_CTRL, 16'h1000, "control");
		rd(`TPC_ADDR_STAT, 16'h3800, "status");
		rd(16'h08F9, 16'h0000, "unmapped");
		chk("amp", {15'h0000, transmit_amplitude_high}, 16'h0001);
		acc(2'b10, `TPC_ADDR_CTRL, 16'hFFFF);
		rd(`TPC_ADDR_CTRL, 16'h5401, "control bits");
		chk("eee", {15'h0000, energy_efficient_enable}, 16'h0001);
		chk("tx off", {13'h0000, pma_tx}, 16'h0000);
		acc(2'b10, `TPC_ADDR_STAT, 16'h0000);
		rd(`TPC_ADDR_STAT, 16'h3800, "status ro");
		acc(2'b10, `TPC_ADDR_CTRL, 16'h0001);
		@(negedge clk_sys);
		chk("amp low", {15'h0000, transmit_amplitude_high}, 16'h0000);
		an_enable = 1'b1;
		an_amplitude_high = 1'b1;
		repeat (2) @(negedge clk_sys);
		chk("amp an", {15'h0000, transmit_amplitude_high}, 16'h0001);
		an_enable = 1'b0;
		for (int m = 0; m < 8; m++) begin
			acc(2'b10, `TPC_ADDR_TEST, {m[2:0], 13'h1FFF});
			rd(`TPC_ADDR_TEST, {m[2:0], 13'h0000}, "test");
			if (m == 1 || m == 2) pat(m == 1 ? 1 : 10);
			else begin
				chk("tx pass", {13'h0000, pma_tx}, {13'h0000, pcs_tx});
				chk("loop", {13'h0000, pma_rx}, {13'h0000, pcs_tx});
			end
		end
		acc(2'b10, `TPC_ADDR_CTRL, 16'h0000);
		@(negedge clk_sys);
		chk("rx", {13'h0000, pma_rx}, {13'h0000, line_rx});
		// second reset in mid-run with the strap low
		sys_rst = 1'b1;
		strap_high_amplitude = 1'b0;
		repeat (3) @(negedge clk_sys);
		sys_rst = 1'b0;
		repeat (2) @(negedge clk_sys);
		rd(`TPC_ADDR_CTRL, 16'h0000, "control strap low");
		rd(`TPC_ADDR_STAT, 16'h2800, "status strap low");
		rd(`TPC_ADDR_TEST, 16'h0000, "test after reset");
		chk("amp strap low", {15'h0000, transmit_amplitude_high}, 16'h0000);
		final_report();
	end
endmodule : tpc_regs_test
